// ### hdl/crf_pkg.sv
// crf_pkg: shared constants for the receiver flag and status block
// assumes an 8-bit register port with word offsets of its own
package crf_pkg;
   localparam int          DATA_W          = 8;
   localparam int          ADDR_W          = 4;
   localparam int          TXERR_W         = 9;
   // register offsets
   localparam logic [3:0]  ADDR_RFLG       = 4'h0;
   localparam logic [3:0]  ADDR_RIER       = 4'h1;
   localparam logic [3:0]  ADDR_CTRL       = 4'h2;
   localparam logic [3:0]  ADDR_TXERR      = 4'h3;
   localparam logic [3:0]  ADDR_FG_DATA    = 4'h4;
   localparam logic [3:0]  ADDR_FIFO_CNT   = 4'h5;
   // flag register field positions
   localparam int          BIT_CSC         = 6;
   localparam int          BIT_RSTAT_HI    = 5;
   localparam int          BIT_RSTAT_LO    = 4;
   localparam int          BIT_TSTAT_HI    = 3;
   localparam int          BIT_TSTAT_LO    = 2;
   localparam int          BIT_OVR         = 1;
   localparam int          BIT_RXF         = 0;
   // enable register fields
   localparam int          BIT_CSCIE       = 6;
   localparam logic [7:0]  RIER_SEL_MASK   = 8'h3c;
   localparam logic [7:0]  RIER_RESET      = 8'h00;
   // control register fields
   localparam int          BIT_INIT_REQ    = 0;
   localparam int          BIT_INIT_ACK    = 1;
   // tx error counter thresholds
   localparam logic [8:0]  TX_WARN_LIMIT   = 9'd96;
   localparam logic [8:0]  TX_ERR_LIMIT    = 9'd127;
   localparam logic [8:0]  TX_BUSOFF_LIMIT = 9'd255;
   // fifo geometry default
   localparam int          FIFO_DEPTH      = 4;
   typedef enum logic [1:0] {
      CRF_TX_OK     = 2'b00,
      CRF_TX_WARN   = 2'b01,
      CRF_TX_ERR    = 2'b10,
      CRF_TX_BUSOFF = 2'b11
   } crf_tx_state_t;
endpackage

// ### hdl/crf_receiver_flags.sv
// crf_receiver_flags: receiver flag register, interrupt enables and
// foreground buffer hand-off for a CAN controller
// assumes the protocol engine delivers one-cycle message pulses on clock
//
// Overview of operation
// - tx status reads 00 for a counter of 0..96 and 01 for 97..127.
// - tx status bits 3:2 show the transmitter state once the status change flag is set.
// - bit 1 sets on a receive overrun and stays set until software clears it.
// - a set, enabled overrun flag keeps the error interrupt request high.
// - bit 0 sets when a new message shifts into the foreground buffer.
// - only messages with matching identifier, good CRC and no other error are stored.
// - while the buffer-full flag is set no further fifo entry moves to the foreground.
// - a set, enabled buffer-full flag keeps the receive interrupt request high.
// - bus-off is entered only when the tx error counter exceeds 255 and forces the rx state.
// - on leaving bus-off the reported receiver state goes straight to ok.
// - the enable register holds one enable per interrupt flag.
// - the enable register, apart from its select fields, is held at reset while init request and acknowledge are both set.
// - the status-change select fields of the enable register ignore init mode.
//
// Chosen here: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`default_nettype none
module crf_receiver_flags
   import crf_pkg::*;
#(
   parameter int DEPTH = FIFO_DEPTH
)(
   // clock and reset
   input  wire logic               clock,
   input  wire logic               rst_n,
   // register port
   input  wire logic [ADDR_W-1:0]  reg_addr,
   input  wire logic [DATA_W-1:0]  reg_wdata,
   input  wire logic               reg_write,
   input  wire logic               reg_read,
   output logic [DATA_W-1:0]       reg_rdata,
   // protocol engine side
   input  wire logic               msg_valid,
   input  wire logic [DATA_W-1:0]  msg_data,
   input  wire logic               msg_id_match,
   input  wire logic               msg_crc_ok,
   input  wire logic               msg_error,
   input  wire logic [1:0]         rx_err_state,
   input  wire logic [TXERR_W-1:0] tx_err_count,
   // init handshake
   output logic                    init_acknowledge,
   // interrupts
   output logic                    rx_irq,
   output logic                    err_irq,
   output logic                    irq
);
   // register state
   logic [DATA_W-1:0]  rier;
   logic               init_request;
   logic               status_change_flag;
   logic               overrun_flag;
   logic               rx_buffer_full_flag;
   logic [DATA_W-1:0]  rx_foreground_buffer;
   logic [1:0]         tx_bus_status_field;
   logic [1:0]         rx_bus_status_field;
   crf_tx_state_t      tx_state_q;
   logic               bus_off_q;
   logic [1:0]         rx_state_q;

   // status decode
   crf_tx_state_t      tx_state;
   logic               bus_off;
   crf_tx_status u_tx_status (
      .tx_err_count (tx_err_count),
      .tx_state     (tx_state),
      .bus_off      (bus_off)
   );

   // receiver state: bus-off forces it, leaving bus-off drops to ok
   wire [1:0] rx_state_eff = bus_off ? 2'h3 :
                             (bus_off_q ? 2'h0 : rx_err_state);

   // fifo in front of the foreground buffer
   logic                          fifo_in_ready;
   logic                          fifo_out_valid;
   logic [DATA_W-1:0]             fifo_out_data;
   logic [$clog2(DEPTH+1)-1:0]    fifo_level;
   wire msg_good   = msg_valid && msg_id_match && msg_crc_ok && !msg_error;
   wire fg_load    = fifo_out_valid && !rx_buffer_full_flag;
   wire overrun_ev = msg_good && !fifo_in_ready;
   crf_rx_fifo #(
      .WIDTH (DATA_W),
      .DEPTH (DEPTH)
   ) u_fifo (
      .clock      (clock),
      .rst_n      (rst_n),
      .push_valid (msg_good),
      .push_data  (msg_data),
      .push_ready (fifo_in_ready),
      .pop_valid  (fifo_out_valid),
      .pop_data   (fifo_out_data),
      .pop_ready  (!rx_buffer_full_flag),
      .level      (fifo_level)
   );

   // bus decode
   wire sel_rflg  = reg_addr == ADDR_RFLG;
   wire sel_rier  = reg_addr == ADDR_RIER;
   wire sel_ctrl  = reg_addr == ADDR_CTRL;
   wire wr_rflg   = reg_write && sel_rflg;
   wire wr_rier   = reg_write && sel_rier;
   wire wr_ctrl   = reg_write && sel_ctrl;
   wire in_init   = init_request && init_acknowledge;
   wire state_chg = (tx_state != tx_state_q) || (rx_state_eff != rx_state_q);

   // write-one-to-clear; a same-cycle set wins
   wire next_csc = state_chg || (status_change_flag && !(wr_rflg && reg_wdata[BIT_CSC]));
   wire next_ovr = overrun_ev || (overrun_flag && !(wr_rflg && reg_wdata[BIT_OVR]));
   wire next_rxf = fg_load || (rx_buffer_full_flag &&
                   !(wr_rflg && reg_wdata[BIT_RXF]));

   // enable register: select fields survive init, the rest is held at reset
   wire [DATA_W-1:0] rier_wr  = wr_rier ? reg_wdata : rier;
   wire [DATA_W-1:0] next_rier = in_init ?
        ((rier_wr & RIER_SEL_MASK) | (RIER_RESET & ~RIER_SEL_MASK)) :
        rier_wr;

   wire [DATA_W-1:0] rflg_view = {1'b0, status_change_flag, rx_bus_status_field,
                                  tx_bus_status_field, overrun_flag, rx_buffer_full_flag};

   wire [DATA_W-1:0] rd_mux =
        sel_rflg ? rflg_view :
        sel_rier ? rier :
        sel_ctrl ? {6'h00, init_acknowledge, init_request} :
        (reg_addr == ADDR_TXERR)    ? (bus_off ? 8'hff : tx_err_count[7:0]) :
        (reg_addr == ADDR_FG_DATA)  ? rx_foreground_buffer :
        (reg_addr == ADDR_FIFO_CNT) ? {{(DATA_W-$clog2(DEPTH+1)){1'b0}}, fifo_level} :
        8'h00;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         status_change_flag  <= 1'b0;
         overrun_flag        <= 1'b0;
         rx_buffer_full_flag <= 1'b0;
      end else begin
         status_change_flag  <= next_csc;
         overrun_flag        <= next_ovr;
         rx_buffer_full_flag <= next_rxf;
      end
   end

   // status fields latch when the change flag sets, so they match the event
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         tx_state_q          <= CRF_TX_OK;
         rx_state_q          <= 2'h0;
         bus_off_q           <= 1'b0;
         tx_bus_status_field <= 2'h0;
         rx_bus_status_field <= 2'h0;
      end else begin
         tx_state_q <= tx_state;
         rx_state_q <= rx_state_eff;
         bus_off_q  <= bus_off;
         if (state_chg) begin
            tx_bus_status_field <= tx_state;
            rx_bus_status_field <= rx_state_eff;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rx_foreground_buffer <= 8'h00;
      end else if (fg_load) begin
         rx_foreground_buffer <= fifo_out_data;
      end
   end

   // init request/ack: ack follows request one cycle later
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         init_request     <= 1'b0;
         init_acknowledge <= 1'b0;
         rier             <= RIER_RESET;
      end else begin
         if (wr_ctrl) init_request <= reg_wdata[BIT_INIT_REQ];
         init_acknowledge <= init_request;
         rier             <= next_rier;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
      end else begin
         reg_rdata <= reg_read ? rd_mux : 8'h00;
      end
   end

   // level requests, high while flag and enable are both set
   assign rx_irq  = rx_buffer_full_flag && rier[BIT_RXF];
   assign err_irq = overrun_flag && rier[BIT_OVR];
   assign irq     = rx_irq || err_irq || (status_change_flag && rier[BIT_CSCIE]);
endmodule
`default_nettype wire

// ### hdl/crf_rx_fifo.sv
// crf_rx_fifo: receive fifo behind the foreground buffer
// assumes one-cycle push pulses from the protocol engine
`timescale 1ns/1ps
`default_nettype none
module crf_rx_fifo
   import crf_pkg::*;
#(
   parameter int WIDTH = DATA_W,
   parameter int DEPTH = FIFO_DEPTH
)(
   // clock and reset
   input  wire logic             clock,
   input  wire logic             rst_n,
   // write side
   input  wire logic             push_valid,
   input  wire logic [WIDTH-1:0] push_data,
   output logic                  push_ready,
   // read side
   output logic                  pop_valid,
   output logic [WIDTH-1:0]      pop_data,
   input  wire logic             pop_ready,
   // fill level
   output logic [$clog2(DEPTH+1)-1:0] level
);
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0]    wr_ptr;
   logic [PW-1:0]    rd_ptr;
   wire do_push = push_valid && push_ready;
   wire do_pop  = pop_valid && pop_ready;
   assign push_ready = level != DEPTH[$clog2(DEPTH+1)-1:0];
   assign pop_valid  = level != '0;
   assign pop_data   = mem[rd_ptr];
   always_ff @(posedge clock) begin
      if (do_push) begin
         mem[wr_ptr] <= push_data;
      end
   end
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         level  <= '0;
      end else begin
         if (do_push) wr_ptr <= wr_ptr + 1'b1;
         if (do_pop)  rd_ptr <= rd_ptr + 1'b1;
         level <= level + (do_push ? 1'b1 : 1'b0) - (do_pop ? 1'b1 : 1'b0);
      end
   end
endmodule
`default_nettype wire

// ### hdl/crf_tx_status.sv
// crf_tx_status: maps the transmit error counter to the two-bit bus status
// assumes the counter is synchronous to clock and saturates above 255
`timescale 1ns/1ps
`default_nettype none
module crf_tx_status
   import crf_pkg::*;
(
   // counter in
   input  wire logic [TXERR_W-1:0] tx_err_count,
   // status out
   output crf_tx_state_t           tx_state,
   output logic                    bus_off
);
   wire in_ok   = tx_err_count <= TX_WARN_LIMIT;
   wire in_warn = !in_ok && tx_err_count <= TX_ERR_LIMIT;
   assign bus_off = tx_err_count > TX_BUSOFF_LIMIT;
   assign tx_state = bus_off ? CRF_TX_BUSOFF :
                     in_ok   ? CRF_TX_OK :
                     in_warn ? CRF_TX_WARN : CRF_TX_ERR;
endmodule
`default_nettype wire

// ### test/crf_node_model.sv
// crf_node_model: far-side stub for the bus and the protocol engine
// assumes go is a one-cycle request from the bench, taken at the rising edge
`timescale 1ns/1ps
`default_nettype none
module crf_node_model
   import crf_pkg::*;
(
   // clock and reset
   input  wire logic              clock,
   input  wire logic              rst_n,
   // bench request
   input  wire logic              go,
   input  wire logic              good,
   input  wire logic [DATA_W-1:0] data,
   // engine side
   output logic                   msg_valid,
   output logic [DATA_W-1:0]      msg_data,
   output logic                   msg_id_match,
   output logic                   msg_crc_ok,
   output logic                   msg_error
);
   // outside a pulse msg_valid drops and the rest toggles so a stale qualifier is never trusted
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         {msg_valid, msg_id_match, msg_crc_ok, msg_error} <= 4'h0;
         msg_data <= '0;
      end else if (go) begin
         msg_valid    <= 1'b1;
         msg_data     <= data;
         msg_id_match <= good;
         msg_crc_ok   <= good;
         msg_error    <= !good;
      end else begin
         msg_valid    <= 1'b0;
         msg_data     <= ~msg_data;
         msg_id_match <= !msg_id_match;
         msg_crc_ok   <= !msg_crc_ok;
         msg_error    <= !msg_error;
      end
   end
endmodule
`default_nettype wire

// ### test/crf_receiver_flags_assertions.sv
// crf_receiver_flags_assertions: port-level checks for the receiver flags
// assumes it is bound into crf_receiver_flags and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module crf_receiver_flags_assertions
   import crf_pkg::*;
#(
   parameter int DEPTH = FIFO_DEPTH
)(
   // clock and reset
   input wire logic               clock,
   input wire logic               rst_n,
   // register port
   input wire logic [ADDR_W-1:0]  reg_addr,
   input wire logic [DATA_W-1:0]  reg_wdata,
   input wire logic               reg_write,
   input wire logic               reg_read,
   input wire logic [DATA_W-1:0]  reg_rdata,
   // engine side
   input wire logic               msg_valid,
   input wire logic [DATA_W-1:0]  msg_data,
   input wire logic               msg_id_match,
   input wire logic               msg_crc_ok,
   input wire logic               msg_error,
   input wire logic [1:0]         rx_err_state,
   input wire logic [TXERR_W-1:0] tx_err_count,
   // outputs
   input wire logic               init_acknowledge,
   input wire logic               rx_irq,
   input wire logic               err_irq,
   input wire logic               irq
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   wire       rd_flg = reg_read && (reg_addr == ADDR_RFLG);
   wire [1:0] exp_ts = (tx_err_count > TX_BUSOFF_LIMIT) ? 2'b11 :
                       (tx_err_count > TX_ERR_LIMIT) ? 2'b10 :
                       (tx_err_count > TX_WARN_LIMIT) ? 2'b01 : 2'b00;
   AST_TSTAT: assert property (
      $stable(tx_err_count)[*3] ##0 rd_flg |=> reg_rdata[3:2] == $past(exp_ts))
      else $error("tx status field does not match the error count");
   AST_BUS_OFF: assert property (
      (tx_err_count > TX_BUSOFF_LIMIT)[*3] ##0 rd_flg |=> reg_rdata[5:2] == 4'hf)
      else $error("bus-off not shown in both state fields");
   // init mode returns the enables to reset, which may drop a request with no write
   AST_RX_HOLD: assert property (
      rx_irq && !reg_write && !$past(reg_write) && !init_acknowledge |=> rx_irq)
      else $error("receive request dropped without a write");
   AST_ERR_HOLD: assert property (
      err_irq && !reg_write && !$past(reg_write) && !init_acknowledge |=> err_irq)
      else $error("error request dropped without a write");
   AST_IRQ_OR: assert property (rx_irq || err_irq |-> irq)
      else $error("combined request missing a source");
   AST_INIT_MASK: assert property (
      init_acknowledge && $past(init_acknowledge) |-> !irq && !rx_irq && !err_irq)
      else $error("request raised while in init mode");
   AST_BAD_MSG: assert property (
      (!rx_irq && !reg_write && !msg_valid)[*3] ##1 (msg_valid && !msg_crc_ok)
      ##1 !reg_write[*2] |-> !rx_irq)
      else $error("faulty message reached the foreground");
   AST_OVR_CAUSE: assert property (
      $rose(err_irq) |-> $past(msg_valid) || $past(msg_valid, 2) || $past(reg_write))
      else $error("error request rose with no cause");
endmodule
bind crf_receiver_flags crf_receiver_flags_assertions #(.DEPTH(DEPTH)) u_chk (
   .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
   .msg_valid(msg_valid), .msg_data(msg_data), .msg_id_match(msg_id_match),
   .msg_crc_ok(msg_crc_ok), .msg_error(msg_error), .rx_err_state(rx_err_state),
   .tx_err_count(tx_err_count), .init_acknowledge(init_acknowledge),
   .rx_irq(rx_irq), .err_irq(err_irq), .irq(irq));
`default_nettype wire

// ### test/crf_receiver_flags_tb.sv
// crf_receiver_flags_tb: self-checking bench for the receiver flag block
// assumes one 100 MHz clock and crf_node_model on the engine side
`timescale 1ns/1ps
`default_nettype none
module crf_receiver_flags_tb;
   import crf_pkg::*;
   logic               clock, rst_n, reg_write, reg_read, go, good;
   logic               msg_valid, msg_id_match, msg_crc_ok, msg_error;
   logic               init_acknowledge, rx_irq, err_irq, irq;
   logic [ADDR_W-1:0]  reg_addr;
   logic [DATA_W-1:0]  reg_wdata, reg_rdata, sdata, msg_data, q, d0;
   logic [1:0]         rx_err_state;
   logic [TXERR_W-1:0] tx_err_count, tc;
   logic [TXERR_W-1:0] cnts [8] = '{9'd0, 9'd96, 9'd97, 9'd127, 9'd128, 9'd255,
                                    9'd256, 9'd511};
   int                 failures = 0, total_checks = 0, cycles = 0, seed, i;

   crf_receiver_flags #(.DEPTH(4)) uut (.clock(clock), .rst_n(rst_n),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
      .reg_read(reg_read), .reg_rdata(reg_rdata), .msg_valid(msg_valid),
      .msg_data(msg_data), .msg_id_match(msg_id_match), .msg_crc_ok(msg_crc_ok),
      .msg_error(msg_error), .rx_err_state(rx_err_state),
      .tx_err_count(tx_err_count), .init_acknowledge(init_acknowledge),
      .rx_irq(rx_irq), .err_irq(err_irq), .irq(irq));
   crf_node_model node (.clock(clock), .rst_n(rst_n), .go(go), .good(good),
      .data(sdata), .msg_valid(msg_valid), .msg_data(msg_data),
      .msg_id_match(msg_id_match), .msg_crc_ok(msg_crc_ok), .msg_error(msg_error));

   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   function automatic logic [1:0] exp_ts(input logic [8:0] c);
      return (c > 255) ? 2'b11 : (c > 127) ? 2'b10 : (c > 96) ? 2'b01 : 2'b00;
   endfunction
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      total_checks++;
      if (g !== e) begin
         failures++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic results();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_write <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_write <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clock);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_read <= 1'b0;
      #1 d = reg_rdata;
   endtask
   // quiet cycles ahead of each message keep the engine pulses apart
   task automatic send(input logic g, input logic [7:0] d);
      repeat (3) @(posedge clock);
      go    <= 1'b1;
      good  <= g;
      sdata <= d;
      @(posedge clock);
      go <= 1'b0;
   endtask
   always @(posedge clock) begin
      cycles = cycles + 1;
      if (cycles == 5000) begin
         failures++;
         results();
      end
   end

   initial begin
      seed = 66711;
      {rst_n, reg_write, reg_read, go, good} = 5'h0;
      reg_addr = '0;
      reg_wdata = '0;
      sdata = '0;
      rx_err_state = 2'b01;
      tx_err_count = '0;
      repeat (8) @(posedge clock);
      rst_n <= 1'b1;
      rd(ADDR_RIER, q);
      chk("enables", RIER_RESET, q);
      wr(ADDR_RIER, 8'h3f);
      rd(ADDR_RIER, q);
      chk("enables", 8'h3f, q);
      wr(4'hf, 8'hff);
      rd(4'hf, q);
      chk("unmapped", 8'h00, q);
      for (i = 0; i < 12; i++) begin
         tc = (i < 8) ? cnts[i] : 9'($random(seed));
         @(posedge clock);
         tx_err_count <= tc;
         repeat (3) @(posedge clock);
         rd(ADDR_RFLG, q);
         chk("state", (tc > 255) ? 8'h0f : {4'h0, rx_err_state, exp_ts(tc)},
             {4'h0, q[5:2]});
         rd(ADDR_TXERR, q);
         chk("tx count", (tc > 255) ? 8'hff : tc[7:0], q);
      end
      // leave bus-off and read the fields one cycle later, before rx state recovers
      @(posedge clock);
      tx_err_count <= 9'd300;
      repeat (3) @(posedge clock);
      tx_err_count <= '0;
      rd(ADDR_RFLG, q);
      chk("rx state", 8'h00, {4'h0, q[5:2]});
      d0 = 8'($random(seed));
      send(1'b0, ~d0);
      repeat (3) @(posedge clock);
      chk("rx irq", 8'h00, {7'h0, rx_irq});
      send(1'b1, d0);
      repeat (3) @(posedge clock);
      chk("rx irq", 8'h01, {7'h0, rx_irq});
      rd(ADDR_FG_DATA, q);
      chk("fg data", d0, q);
      for (i = 0; i < 5; i++) send(1'b1, d0 + 8'(i + 1));
      repeat (3) @(posedge clock);
      chk("err irq", 8'h01, {7'h0, err_irq});
      rd(ADDR_FIFO_CNT, q);
      chk("fifo level", 8'h04, q);
      rd(ADDR_FG_DATA, q);
      chk("fg data", d0, q);
      wr(ADDR_RFLG, 8'h02);
      chk("err irq", 8'h00, {7'h0, err_irq});
      wr(ADDR_RFLG, 8'h01);
      repeat (3) @(posedge clock);
      rd(ADDR_FG_DATA, q);
      chk("fg data", d0 + 8'h01, q);
      chk("rx irq", 8'h01, {7'h0, rx_irq});
      wr(ADDR_RIER, 8'h3e);
      chk("rx irq", 8'h00, {7'h0, rx_irq});
      wr(ADDR_CTRL, 8'h01);
      repeat (2) @(posedge clock);
      chk("init ack", 8'h01, {7'h0, init_acknowledge});
      rd(ADDR_CTRL, q);
      chk("ctrl", 8'h03, q);
      wr(ADDR_RIER, 8'hff);
      rd(ADDR_RIER, q);
      chk("enables", 8'h3c, q);
      chk("irq", 8'h00, {7'h0, irq});
      wr(ADDR_CTRL, 8'h00);
      repeat (2) @(posedge clock);
      chk("init ack", 8'h00, {7'h0, init_acknowledge});
      results();
   end
endmodule
`default_nettype wire
